// >>> design/duc_coeff_reader.sv
/*
 * calibration coefficient memory with a delayed byte read.
 * assumes start is a one-cycle pulse from the register decode on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module duc_coeff_reader #(
    parameter int READ_CYCLES = duc_pkg::COEFF_READ_CYCLES
) (
    input  wire logic                            clk,
    input  wire logic                            nrst,
    input  wire logic                            start,
    input  wire logic [duc_pkg::CAL_ADDR_W-1:0]  addr,
    input  wire duc_pkg::duc_cal_ld_t            cal_ld,
    output logic                                 ready,
    output logic [7:0]                           rbyte
);
    import duc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } duc_rd_state_t;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(READ_CYCLES - 1);

    // signed quarter-lsb coefficients, offset then gain, two bytes each per channel
    logic [7:0]            mem [CAL_DEPTH];
    duc_rd_state_t         state, next_state;
    logic [CNT_W-1:0]      cnt, next_cnt;
    logic [CAL_ADDR_W-1:0] raddr, next_raddr;
    logic                  next_ready;
    logic [7:0]            next_rbyte;

    always_ff @(posedge clk) begin
        if (cal_ld.en) begin
            mem[cal_ld.addr] <= cal_ld.data; // [RULE8]
        end
    end

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_raddr = raddr;
        next_ready = ready;
        next_rbyte = rbyte;
        case (state)
            ST_IDLE: begin
            end
            ST_WAIT: begin
                if (cnt == LAST) begin
                    next_state = ST_IDLE;
                    next_ready = 1'b1;        // [RULE6] [RULE11]
                    next_rbyte = mem[raddr];
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (start) begin
            next_state = ST_WAIT;
            next_cnt   = '0;
            next_raddr = addr;
            next_ready = 1'b0;                // [RULE10]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            cnt   <= '0;
            raddr <= '0;
            ready <= 1'b0;                    // [RULE10]
            rbyte <= 8'h00;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            raddr <= next_raddr;
            ready <= next_ready;
            rbyte <= next_rbyte;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_start_clears_ready: assert property (start |=> !ready) // [RULE10]
        else $error("ready not cleared by a new read");
    chk_ready_after_delay: assert property (!ready ##1 ready |-> $past(cnt) == LAST) // [RULE11]
        else $error("ready rose before the read delay ended");
    chk_byte_from_memory: assert property (!ready ##1 ready |-> rbyte == mem[raddr]) // [RULE6]
        else $error("returned byte differs from memory");
    chk_wait_holds_low: assert property (state == ST_WAIT && cnt != LAST && !start |=> !ready) // [RULE11]
        else $error("ready high while still waiting");
    cov_read_done: cover property (start ##[1:1000] ready);
endmodule
`default_nettype wire

// >>> design/duc_pkg.sv
/*
 * shared constants and carrier types of the dac update and coefficient readout block.
 * assumes a 250 MHz core clock and a 16-bit register port with byte offsets.
 */
package duc_pkg;
    localparam int          NUM_CH          = 8;
    localparam int          CODE_W          = 16;
    localparam int          ADDR_W          = 12;
    localparam int          CAL_ADDR_W      = 7;
    localparam int          CAL_DEPTH       = 128;

    // register byte offsets
    localparam logic [11:0] OFS_CONTROL     = 12'h0200;
    localparam logic [11:0] OFS_COEFF_REQ   = 12'h0214;
    localparam logic [11:0] OFS_COEFF_STAT  = 12'h0219;
    localparam logic [11:0] OFS_LAUNCH      = 12'h021C;
    localparam logic [11:0] OFS_CH0         = 12'h0220;
    localparam logic [11:0] OFS_CH_LAST     = 12'h023C;
    localparam logic [11:0] CH_STRIDE       = 12'h0004;

    // field positions
    localparam int          CTRL_MODE_LSB   = 5;
    localparam int          CTRL_SINGLE_BIT = 8;
    localparam int          REQ_GO_BIT      = 15;
    localparam int          REQ_ADDR_LSB    = 8;
    localparam int          STAT_READY_BIT  = 0;
    localparam int          STAT_BYTE_LSB   = 8;
    localparam int          LAUNCH_BIT      = 0;

    // trigger mode encodings and reset values
    localparam logic [1:0]  MODE_ALL        = 2'h0;
    localparam logic [1:0]  MODE_EXT_ONLY   = 2'h1;
    localparam logic [15:0] CONTROL_RST     = 16'h0000;
    localparam logic [15:0] CODE_RST        = 16'h0000;

    // timing
    localparam int          CLK_MHZ         = 250;
    localparam int          COEFF_READ_NS   = 2_500_000;
    localparam int          COEFF_READ_CYCLES = COEFF_READ_NS * CLK_MHZ / 1000;
    localparam int          CNT_W           = 20;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [15:0]       data;
    } duc_req_t;

    typedef struct packed {
        logic                  en;
        logic [CAL_ADDR_W-1:0] addr;
        logic [7:0]            data;
    } duc_cal_ld_t;
endpackage

// >>> design/duc_top.sv
/*
 * register block of a multi-channel 16-bit analog output card: trigger control,
 * channel data registers with simultaneous launch, and coefficient byte readout.
 * assumes a host register port on CLK with one-cycle wr/rd strobes and byte offsets.
 */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1 - control value 0100 hex enables external, software and timer triggers, single conversion.
// RULE2 - each channel register holds a 16-bit unsigned code, channel 0 at offset 220 hex.
// RULE3 - writing 0001 hex to the launch register moves all codes to their converters at once; the code ignores it in external-only trigger mode.
// RULE4 - request 8000 hex reads offset upper byte of channel 0, 8100 hex its lower byte.
// RULE5 - request 8200 hex reads gain upper byte of channel 0, 8300 hex its lower byte.
// RULE6 - status bit 0 rises when the byte is ready and bits 15 to 8 carry that byte.
// RULE7 - the host reads each coefficient as two byte reads, upper then lower, polling bit 0.
// RULE8 - the calibration memory holds signed quarter-lsb gain and offset values per channel.
// RULE9 - the host clamps computed codes to the range 0 to 65535 before writing them.
// RULE10 - the ready flag clears when a new coefficient read starts and on reset.
// RULE11 - a requested coefficient byte reaches the status register about 2.5 ms after request.
// RULE12 - reset clears every channel data register to zero.
// RULE13 - further channel registers follow channel 0 at a four-byte stride.
module duc_top #(
    parameter int READ_CYCLES = duc_pkg::COEFF_READ_CYCLES
) (
    input  wire logic                                            CLK,
    input  wire logic                                            NRST,
    input  wire duc_pkg::duc_req_t                               REQ,
    input  wire duc_pkg::duc_cal_ld_t                            CAL_LD,
    output logic [15:0]                                          RDATA,
    output logic                                                 RVALID,
    output logic [duc_pkg::NUM_CH-1:0][duc_pkg::CODE_W-1:0]      DAC_CODE,
    output logic                                                 DAC_UPDATE,
    output logic                                                 TRIG_EXT_EN,
    output logic                                                 TRIG_SW_EN,
    output logic                                                 TRIG_TIMER_EN,
    output logic                                                 SINGLE_MODE
);
    import duc_pkg::*;

    logic [15:0]                     control, next_control;
    logic [NUM_CH-1:0][CODE_W-1:0]   chan, next_chan;
    logic [NUM_CH-1:0][CODE_W-1:0]   next_dac_code;
    logic                            next_dac_update;
    logic [15:0]                     next_rdata;
    logic                            next_rvalid;
    logic                            launch;
    logic                            coeff_start;
    logic                            coeff_ready;
    logic [7:0]                      coeff_byte;
    logic                            ch_hit;
    logic [2:0]                      ch_idx;
    logic [1:0]                      mode;

    // channel address window, word aligned
    assign ch_hit = REQ.addr >= OFS_CH0 && REQ.addr <= OFS_CH_LAST && REQ.addr[1:0] == 2'b00;
    assign ch_idx = 3'((REQ.addr - OFS_CH0) / CH_STRIDE); // [RULE13]

    // trigger source decode
    assign mode          = control[CTRL_MODE_LSB +: 2];
    assign TRIG_EXT_EN   = 1'b1;                            // [RULE1]
    assign TRIG_SW_EN    = mode != MODE_EXT_ONLY;           // [RULE1]
    assign TRIG_TIMER_EN = mode == MODE_ALL;                // [RULE1]
    assign SINGLE_MODE   = control[CTRL_SINGLE_BIT];        // [RULE1]

    assign launch = REQ.wr && REQ.addr == OFS_LAUNCH && REQ.data[LAUNCH_BIT]
                    && TRIG_SW_EN;                          // [RULE3]
    assign coeff_start = REQ.wr && REQ.addr == OFS_COEFF_REQ
                         && REQ.data[REQ_GO_BIT];           // [RULE4] [RULE5]

    always_comb begin
        next_control = control;
        if (REQ.wr && REQ.addr == OFS_CONTROL) begin
            next_control = REQ.data;                        // [RULE1]
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            always_comb begin
                next_chan[g] = chan[g];
                if (REQ.wr && ch_hit && ch_idx == 3'(g)) begin
                    next_chan[g] = REQ.data;                // [RULE2] [RULE13]
                end
            end
        end
    endgenerate

    always_comb begin
        next_dac_code   = DAC_CODE;
        next_dac_update = launch;
        if (launch) begin
            next_dac_code = chan;                           // [RULE3]
        end
        next_rvalid = REQ.rd;
        next_rdata  = 16'h0000;
        if (REQ.rd) begin
            case (REQ.addr)
                OFS_CONTROL:    next_rdata = control;
                OFS_COEFF_STAT: next_rdata = {coeff_byte, 7'h00, coeff_ready}; // [RULE6]
                default:        next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            control    <= CONTROL_RST;
            chan       <= '0;                               // [RULE12]
            DAC_CODE   <= '0;
            DAC_UPDATE <= 1'b0;
            RDATA      <= 16'h0000;
            RVALID     <= 1'b0;
        end else begin
            control    <= next_control;
            chan       <= next_chan;
            DAC_CODE   <= next_dac_code;
            DAC_UPDATE <= next_dac_update;
            RDATA      <= next_rdata;
            RVALID     <= next_rvalid;
        end
    end

    // request bits 14:8 address the byte: 00 offset hi, 01 offset lo, 02 gain hi, 03 gain lo
    duc_coeff_reader #(
        .READ_CYCLES (READ_CYCLES)
    ) u_coeff (
        .clk    (CLK),
        .nrst   (NRST),
        .start  (coeff_start),
        .addr   (REQ.data[REQ_ADDR_LSB +: CAL_ADDR_W]),     // [RULE4] [RULE5]
        .cal_ld (CAL_LD),
        .ready  (coeff_ready),
        .rbyte  (coeff_byte)
    );

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    chk_ctrl_decode: assert property ( // [RULE1]
        REQ.wr && REQ.addr == OFS_CONTROL && REQ.data == 16'h0100
        |=> TRIG_EXT_EN && TRIG_SW_EN && TRIG_TIMER_EN && SINGLE_MODE)
        else $error("control 0100 did not enable all triggers");
    chk_launch_moves: assert property ( // [RULE3]
        launch |=> DAC_UPDATE && DAC_CODE == $past(chan))
        else $error("launch did not move channel codes");
    chk_ch0_write: assert property ( // [RULE2]
        REQ.wr && REQ.addr == OFS_CH0 |=> chan[0] == $past(REQ.data))
        else $error("channel 0 register not written");
    chk_ch_stride: assert property ( // [RULE13]
        REQ.wr && REQ.addr == OFS_CH0 + 3 * CH_STRIDE
        |=> chan[3] == $past(REQ.data) && $stable(chan[1]))
        else $error("channel stride decode wrong");
    chk_offset_req: assert property ( // [RULE4]
        REQ.wr && REQ.addr == OFS_COEFF_REQ && REQ.data == 16'h8100
        |=> u_coeff.raddr == 7'h01 && !coeff_ready)
        else $error("offset low byte request not started");
    chk_gain_req: assert property ( // [RULE5]
        REQ.wr && REQ.addr == OFS_COEFF_REQ && REQ.data == 16'h8200
        |=> u_coeff.raddr == 7'h02 && !coeff_ready)
        else $error("gain high byte request not started");
    chk_status_read: assert property ( // [RULE6]
        REQ.rd && REQ.addr == OFS_COEFF_STAT
        |=> RVALID && RDATA[0] == $past(coeff_ready) && RDATA[15:8] == $past(coeff_byte))
        else $error("status read shows wrong flag or byte");
    chk_update_pulse: assert property (DAC_UPDATE |=> !DAC_UPDATE || $past(launch))  // [RULE3]
        else $error("update pulse stretched without launch");

    cov_launch: cover property (launch);
    cov_ext_only: cover property (mode == MODE_EXT_ONLY && REQ.wr && REQ.addr == OFS_LAUNCH);
    cov_status_ready: cover property (REQ.rd && REQ.addr == OFS_COEFF_STAT && coeff_ready);
endmodule
`default_nettype wire

// >>> testbench/dac_update_and_coeff_readout_tb_top.sv
/* self-checking bench for duc_top: control, launch, refusal, coefficient reads, reset.
   assumes duc_pkg and duc_host_model; READ_CYCLES shortened to 20. */
`timescale 1ns/1ps
`default_nettype none
module dac_update_and_coeff_readout_tb_top;
    import duc_pkg::*;
    localparam int RC = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    duc_req_t req;
    duc_cal_ld_t cal_ld = '0;
    logic [15:0] rdata;
    logic rvalid;
    logic [NUM_CH-1:0][CODE_W-1:0] dac_code;
    logic [NUM_CH-1:0][CODE_W-1:0] exp_code;
    logic dac_update, t_ext, t_sw, t_tim, single;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int upd = 0;
    // offset 43 and gain -185, quarter-lsb two's complement
    logic [7:0] mem [4] = '{8'h00, 8'h2B, 8'hFF, 8'h47};

    duc_host_model i_host (.CLK(clk), .REQ(req), .RDATA(rdata));
    duc_top #(.READ_CYCLES(RC)) i_dut (
        .CLK(clk), .NRST(nrst), .REQ(req), .CAL_LD(cal_ld), .RDATA(rdata),
        .RVALID(rvalid), .DAC_CODE(dac_code), .DAC_UPDATE(dac_update),
        .TRIG_EXT_EN(t_ext), .TRIG_SW_EN(t_sw), .TRIG_TIMER_EN(t_tim),
        .SINGLE_MODE(single));

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (dac_update === 1'b1) upd++;
        if (cyc == 4000) begin
            failures++;
            final_report();
        end
    end

    task automatic chk(string n, logic [127:0] seen, logic [127:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic t_reset_state();
        chk("codes", dac_code, '0);
        chk("trig", {t_ext, t_sw, t_tim, single}, 4'b1110);
    endtask
    task automatic t_single();
        i_host.wr(OFS_CONTROL, 16'h0100);
        chk("trig", {t_ext, t_sw, t_tim, single}, 4'b1111);
    endtask
    task automatic t_launch();
        int n;
        for (int i = 0; i < NUM_CH; i++) begin
            exp_code[i] = i_host.clamp((i == 6) ? -5 : (i == 7) ? 70000 : 32767 - i);
            i_host.wr(OFS_CH0 + 12'(i) * CH_STRIDE, exp_code[i]);
        end
        chk("held", dac_code, '0);
        n = upd;
        i_host.wr(OFS_LAUNCH, 16'h0001);
        repeat (2) @(negedge clk);
        chk("update", upd, n + 1);
        chk("codes", dac_code, exp_code);
    endtask
    task automatic t_ext_only();
        int n;
        i_host.wr(OFS_CONTROL, 16'h0020);
        chk("trig", {t_ext, t_sw, t_tim, single}, 4'b1000);
        i_host.wr(OFS_CH0, 16'h1234);
        n = upd;
        i_host.wr(OFS_LAUNCH, 16'h0001);
        repeat (2) @(negedge clk);
        chk("refused", {upd[7:0], dac_code[0]}, {n[7:0], 16'h7FFF});
        i_host.wr(OFS_CONTROL, 16'h0040);
        chk("trig", {t_ext, t_sw, t_tim, single}, 4'b1100);
        i_host.wr(OFS_CONTROL, 16'h0100);
        i_host.wr(OFS_LAUNCH, 16'h0001);
        repeat (2) @(negedge clk);
        chk("ch0", dac_code[0], 16'h1234);
    endtask
    task automatic coeff_read(int k);
        logic [15:0] s;
        int t0;
        i_host.wr(OFS_COEFF_REQ, {1'b1, 7'(k), 8'h00});
        t0 = cyc;
        i_host.rd(OFS_COEFF_STAT, s);
        chk("cleared", s[0], 1'b0);
        for (int p = 0; p < 40 && s[0] !== 1'b1; p++) i_host.rd(OFS_COEFF_STAT, s);
        chk("delay", (cyc - t0 >= RC) && (cyc - t0 <= RC + 6), 1'b1);
        chk("status", s, {mem[k], 8'h01});
    endtask
    task automatic t_coeff();
        i_host.wr(OFS_COEFF_REQ, 16'h8100);
        repeat (5) @(negedge clk);
        coeff_read(0);
        coeff_read(1);
        coeff_read(2);
        coeff_read(3);
    endtask
    task automatic t_mid_reset();
        logic [15:0] s;
        int n;
        i_host.wr(OFS_CH0, 16'hABCD);
        @(negedge clk);
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        chk("codes", dac_code, '0);
        nrst = 1'b1;
        i_host.rd(OFS_COEFF_STAT, s);
        chk("status", s, 16'h0000);
        chk("rvalid", rvalid, 1'b1);
        n = upd;
        i_host.wr(OFS_LAUNCH, 16'h0001);
        repeat (2) @(negedge clk);
        chk("update", upd, n + 1);
        chk("cleared codes", dac_code, '0);
        i_host.rd(12'h0FF0, s);
        chk("unmapped", s, 16'h0000);
    endtask

    initial begin
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cal_ld <= '{en: 1'b1, addr: 7'(i), data: mem[i]};
            @(negedge clk);
        end
        cal_ld <= '0;
        t_reset_state();
        t_single();
        t_launch();
        t_ext_only();
        t_coeff();
        t_mid_reset();
        final_report();
    end
endmodule
`default_nettype wire

// >>> testbench/duc_host_model.sv
/* host side of the register port: byte-offset writes and reads, code clamping.
   assumes the bench calls its tasks; requests change at falling CLK edges. */
`timescale 1ns/1ps
`default_nettype none
module duc_host_model
    import duc_pkg::*;
(
    input  wire logic        CLK,
    output var duc_pkg::duc_req_t REQ,
    input  wire logic [15:0] RDATA
);
    initial REQ = '0;
    // idle address is inverted, and write data too (read data idles at 0000), so stale values never pass
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(negedge CLK);
        REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(negedge CLK);
        REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(negedge CLK);
        REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'hFFFF};
        @(negedge CLK);
        d = RDATA;
        REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 16'h0000};
    endtask
    function automatic logic [15:0] clamp(input int v);
        return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hFFFF : 16'(v);
    endfunction
endmodule
`default_nettype wire
